// ===== rtl/lane_mask_gen.sv
// byte lane mask generator from address alignment and funct3
`timescale 1ns/1ps
`include "lsa_params.svh"

module lane_mask_gen (
  input wire logic [1:0] adr_low,
  input wire logic [2:0] funct3,
  output lsa_pkg::lane_mask_t lane_mask,
  output logic half_misaligned,
  output logic bad_funct3
);

  // ----------------------------------------------------------------
  // mask decode
  // ----------------------------------------------------------------

  // one bit per byte of the word; only contiguous shapes exist here
  always_comb begin
    lane_mask = `MASK_NONE;
    half_misaligned = 1'b0;
    bad_funct3 = 1'b0;
    unique case (lsa_pkg::access_of(funct3))
      lsa_pkg::acc_byte: begin
        unique case (adr_low)
          2'h0: lane_mask = `MASK_B0;
          2'h1: lane_mask = `MASK_B1;
          2'h2: lane_mask = `MASK_B2;
          2'h3: lane_mask = `MASK_B3;
        endcase
      end
      lsa_pkg::acc_half: begin
        unique case (adr_low)
          2'h0: lane_mask = `MASK_H_LO;
          2'h2: lane_mask = `MASK_H_HI;
          // odd halfword would straddle lanes; nothing is touched
          default: begin
            lane_mask = `MASK_NONE;
            half_misaligned = 1'b1;
          end
        endcase
      end
      lsa_pkg::acc_word: lane_mask = `MASK_WORD;
      lsa_pkg::acc_none: begin
        lane_mask = `MASK_NONE;
        bad_funct3 = 1'b1;
      end
    endcase
  end

endmodule

// ===== rtl/load_store_lane_alignment.sv
// load/store lane alignment path: lane mask, load extender, store handler
//
// Contract
// - four-bit mask, one bit per byte
// - mask from address bits 1:0, funct3
// - byte masks 0001, 0010, 0100, 1000
// - halfword masks 0011, 1100; odd invalid
// - word access gives mask 1111
// - mask goes to port, extender, store
// - memory address low two bits zero
// - no word crossing, no split masks
// - word load passes data unchanged
// - selected lanes moved to low bits
// - signed load copies top bit upward
// - unsigned or positive loads zero-fill
// - store puts data in lanes, rest zero
// - store never extends; 1111 passes word
`timescale 1ns/1ps
`include "lsa_params.svh"

module load_store_lane_alignment #(
  parameter int DATA_W = 32,
  parameter int LANES = 4
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [DATA_W-1:0] alu_result,
  input wire logic [2:0] funct3,
  input wire logic [DATA_W-1:0] reg_store_data,
  input wire logic [DATA_W-1:0] mem_read_data,
  output logic [DATA_W-1:0] mem_addr,
  output logic [LANES-1:0] mem_lane_mask,
  output logic [DATA_W-1:0] mem_write_data,
  output logic [DATA_W-1:0] load_result,
  output logic half_misaligned,
  output logic bad_funct3
);

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------

  // index of the lowest selected lane; zero for an empty mask
  function automatic logic [1:0] first_lane(input logic [LANES-1:0] m);
    logic [1:0] idx;
    idx = 2'h0;
    for (int i = LANES - 1; i >= 0; i--) begin
      if (m[i]) begin
        idx = 2'(i);
      end
    end
    return idx;
  endfunction

  // number of selected lanes
  function automatic logic [2:0] lane_count(input logic [LANES-1:0] m);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < LANES; i++) begin
      n = n + {2'h0, m[i]};
    end
    return n;
  endfunction

  // a legal mask is one byte lane, lanes 1:0, lanes 3:2 or all four lanes
  function automatic logic mask_is_legal(input logic [LANES-1:0] m);
    unique case (m)
      `MASK_B0, `MASK_B1, `MASK_B2, `MASK_B3: return 1'b1;
      `MASK_H_LO, `MASK_H_HI, `MASK_WORD: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // widen a lane mask into a bit mask over the whole word
  function automatic logic [DATA_W-1:0] lane_bits(input logic [LANES-1:0] m);
    logic [DATA_W-1:0] b;
    b = '0;
    for (int i = 0; i < LANES; i++) begin
      b[i*`BYTE_BITS +: `BYTE_BITS] = {`BYTE_BITS{m[i]}};
    end
    return b;
  endfunction

  // ----------------------------------------------------------------
  // lane mask generation
  // ----------------------------------------------------------------

  logic [LANES-1:0] raw_mask;
  logic raw_misaligned;
  logic raw_bad_funct3;
  logic [LANES-1:0] lane_mask;

  lane_mask_gen mask_gen (
    .adr_low (alu_result[`ADDR_LOW_BITS-1:0]),
    .funct3 (funct3),
    .lane_mask (raw_mask),
    .half_misaligned (raw_misaligned),
    .bad_funct3 (raw_bad_funct3)
  );

  // a split or partial pattern is never passed on, even if decode slipped
  always_comb begin
    lane_mask = mask_is_legal(raw_mask) ? raw_mask : `MASK_NONE;
  end

  // ----------------------------------------------------------------
  // load extender
  // ----------------------------------------------------------------

  logic [1:0] shift_lanes;
  logic [2:0] width_lanes;
  logic [DATA_W-1:0] load_shifted;
  logic [DATA_W-1:0] load_low;
  logic load_top;
  logic load_signed;
  logic [DATA_W-1:0] next_load_result;

  // the shift amount and width come from the same mask the port sees
  always_comb begin
    shift_lanes = first_lane(lane_mask);
    width_lanes = lane_count(lane_mask);
  end

  // bring the selected lanes down to bit 0
  always_comb begin
    load_shifted = mem_read_data >> ({3'h0, shift_lanes} * 5'(`BYTE_BITS));
  end

  // keep only the lanes that belong to the access
  always_comb begin
    load_low = '0;
    load_top = 1'b0;
    unique case (width_lanes)
      3'h1: begin
        load_low[`BYTE_BITS-1:0] = load_shifted[`BYTE_BITS-1:0];
        load_top = load_shifted[`BYTE_BITS-1];
      end
      3'h2: begin
        load_low[2*`BYTE_BITS-1:0] = load_shifted[2*`BYTE_BITS-1:0];
        load_top = load_shifted[2*`BYTE_BITS-1];
      end
      3'h4: begin
        load_low = mem_read_data;
        load_top = 1'b0;
      end
      // empty mask: nothing was read, result stays zero
      default: begin
        load_low = '0;
        load_top = 1'b0;
      end
    endcase
  end

  // signed when funct3 bit 2 is clear
  always_comb begin
    load_signed = ~funct3[`F3_SIGN_BIT];
  end

  // fill the upper bits from the realigned top bit or with zeros
  always_comb begin
    next_load_result = load_low;
    if (width_lanes == 3'h4) begin
      next_load_result = mem_read_data;
    end else if (load_signed && load_top) begin
      next_load_result = load_low | ~lane_bits(`MASK_WORD >> (LANES - width_lanes));
    end else begin
      next_load_result = load_low;
    end
  end

  // ----------------------------------------------------------------
  // store handler
  // ----------------------------------------------------------------

  logic [DATA_W-1:0] store_shifted;
  logic [DATA_W-1:0] next_write_data;

  // low bits of the register go up into the selected lanes
  always_comb begin
    store_shifted = reg_store_data << ({3'h0, shift_lanes} * 5'(`BYTE_BITS));
  end

  // lanes outside the mask are forced low; no extension of any kind
  always_comb begin
    if (lane_mask == `MASK_WORD) begin
      next_write_data = reg_store_data;
    end else begin
      next_write_data = store_shifted & lane_bits(lane_mask);
    end
  end

  // ----------------------------------------------------------------
  // data port address
  // ----------------------------------------------------------------

  logic [DATA_W-1:0] next_addr;

  // memory only ever sees word addresses
  always_comb begin
    next_addr = {alu_result[DATA_W-1:`ADDR_LOW_BITS], `ADDR_LOW_ZERO};
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------

  logic next_misaligned;
  logic next_bad_funct3;

  // flags explain why the mask came out empty
  always_comb begin
    next_misaligned = raw_misaligned;
    next_bad_funct3 = raw_bad_funct3;
  end

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------

  // one cycle of latency keeps every output straight off a flop;
  // the caller must hold inputs for the cycle it wants answered
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mem_addr <= `RST_WORD;
      mem_lane_mask <= `RST_MASK;
      mem_write_data <= `RST_WORD;
      load_result <= `RST_WORD;
      half_misaligned <= `RST_FLAG;
      bad_funct3 <= `RST_FLAG;
    end else begin
      mem_addr <= next_addr;
      mem_lane_mask <= lane_mask;
      mem_write_data <= next_write_data;
      load_result <= next_load_result;
      half_misaligned <= next_misaligned;
      bad_funct3 <= next_bad_funct3;
    end
  end

endmodule

// ===== rtl/lsa_params.svh
// constants for the load/store lane alignment path
`ifndef LSA_PARAMS_SVH
`define LSA_PARAMS_SVH

// ----------------------------------------------------------------
// funct3 encodings of loads and stores
// ----------------------------------------------------------------
`define F3_BYTE_S 3'h0
`define F3_HALF_S 3'h1
`define F3_WORD 3'h2
`define F3_BYTE_U 3'h4
`define F3_HALF_U 3'h5
`define F3_SIGN_BIT 2

// ----------------------------------------------------------------
// lane masks
// ----------------------------------------------------------------
`define MASK_NONE 4'h0
`define MASK_B0 4'h1
`define MASK_B1 4'h2
`define MASK_B2 4'h4
`define MASK_B3 4'h8
`define MASK_H_LO 4'h3
`define MASK_H_HI 4'hC
`define MASK_WORD 4'hF

// ----------------------------------------------------------------
// address layout and reset values
// ----------------------------------------------------------------
`define ADDR_LOW_BITS 2
`define ADDR_LOW_ZERO 2'h0
`define BYTE_BITS 8
`define RST_WORD 32'h0000_0000
`define RST_MASK 4'h0
`define RST_FLAG 1'h0

`endif

// ===== rtl/lsa_pkg.sv
// types and shared decode for the load/store lane alignment path
package lsa_pkg;

  // ----------------------------------------------------------------
  // access sizes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    acc_none,
    acc_byte,
    acc_half,
    acc_word
  } access_t;

  typedef logic [3:0] lane_mask_t;
  typedef logic [31:0] word_t;

  // decode of funct3 into an access size; used by lane_mask_gen
  function automatic access_t access_of(input logic [2:0] f3);
    unique case (f3)
      3'h0, 3'h4: access_of = acc_byte;
      3'h1, 3'h5: access_of = acc_half;
      3'h2: access_of = acc_word;
      default: access_of = acc_none;
    endcase
  endfunction

endpackage

// ===== sim/load_store_lane_alignment_props.sv
// assertion checker for the load/store lane alignment path
`timescale 1ns/1ps
module load_store_lane_alignment_props #(
  parameter int DATA_W = 32,
  parameter int LANES = 4
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [DATA_W-1:0] alu_result,
  input wire logic [2:0] funct3,
  input wire logic [DATA_W-1:0] reg_store_data,
  input wire logic [DATA_W-1:0] mem_read_data,
  input wire logic [DATA_W-1:0] mem_addr,
  input wire logic [LANES-1:0] mem_lane_mask,
  input wire logic [DATA_W-1:0] mem_write_data,
  input wire logic [DATA_W-1:0] load_result,
  input wire logic half_misaligned,
  input wire logic bad_funct3
);
  logic ok;
  logic [2:0] f3;
  logic [DATA_W-1:0] adr;
  logic [DATA_W-1:0] rd;
  logic [DATA_W-1:0] sd;
  logic [1:0] lo;
  logic [7:0] byt;
  logic [15:0] hw;
  // ----
  // inputs of the previous edge; ok stays low until one clean sample
  // ----
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ok <= 1'b0;
    end else begin
      ok <= 1'b1;
    end
  end
  always_ff @(posedge clock) begin
    f3 <= funct3;
    adr <= alu_result;
    rd <= mem_read_data;
    sd <= reg_store_data;
  end
  assign lo = adr[1:0];
  assign byt = 8'(rd >> (8 * lo));
  assign hw = 16'(rd >> (8 * lo));
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_addr_cut: assert property (ok |-> mem_addr == {adr[DATA_W-1:2], 2'h0})
    else $error("address low bits not cut");
  a_zero_byte: assert property (ok && f3 == 3'h4
    |-> load_result == {24'h0, byt})
    else $error("unsigned byte load wrong");
  a_byte_mask: assert property (ok && (f3 == 3'h0 || f3 == 3'h4)
    |-> mem_lane_mask == 4'h1 << lo)
    else $error("byte mask wrong");
  a_half_lane: assert property (ok && f3[1:0] == 2'h1 && !lo[0]
    |-> mem_lane_mask == (lo[1] ? 4'hC : 4'h3))
    else $error("halfword mask wrong");
  a_half_odd: assert property (ok && f3[1:0] == 2'h1 && lo[0]
    |-> half_misaligned && mem_lane_mask == 4'h0)
    else $error("odd halfword not refused");
  a_word_pass: assert property (ok && f3 == 3'h2
    |-> mem_lane_mask == 4'hF && load_result == rd && mem_write_data == sd)
    else $error("word access altered");
  a_mask_legal: assert property (
    mem_lane_mask inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF})
    else $error("split lane mask");
  a_store_byte: assert property (ok && f3 == 3'h0
    |-> mem_write_data == {24'h0, sd[7:0]} << (8 * lo))
    else $error("store byte misplaced");
  a_store_half: assert property (ok && f3[1:0] == 2'h1 && !lo[0]
    |-> mem_write_data == {16'h0, sd[15:0]} << (8 * lo))
    else $error("store halfword misplaced");
  a_sign_byte: assert property (ok && f3 == 3'h0
    |-> load_result == {{24{byt[7]}}, byt})
    else $error("signed byte load wrong");
  a_sign_half: assert property (ok && f3 == 3'h1 && !lo[0]
    |-> load_result == {{16{hw[15]}}, hw})
    else $error("signed halfword load wrong");
  a_zero_half: assert property (ok && f3 == 3'h5 && !lo[0]
    |-> load_result == {16'h0, hw})
    else $error("unsigned halfword load wrong");
  a_bad_code: assert property (ok && f3 inside {3'h3, 3'h6, 3'h7}
    |-> bad_funct3 && mem_lane_mask == 4'h0)
    else $error("bad funct3 not refused");
endmodule
bind load_store_lane_alignment load_store_lane_alignment_props #(.DATA_W(DATA_W), .LANES(LANES)) u_props (
  .clock(clock), .rst(rst), .alu_result(alu_result), .funct3(funct3),
  .reg_store_data(reg_store_data), .mem_read_data(mem_read_data), .mem_addr(mem_addr),
  .mem_lane_mask(mem_lane_mask), .mem_write_data(mem_write_data), .load_result(load_result),
  .half_misaligned(half_misaligned), .bad_funct3(bad_funct3));

// ===== sim/load_store_lane_alignment_tb.sv
// self-checking testbench for the load/store lane alignment path
`timescale 1ns/1ps
module load_store_lane_alignment_tb;
  localparam logic [31:0] SD = 32'hA5C31E96;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [31:0] alu_result = 32'h0;
  logic [2:0] funct3 = 3'h0;
  // store data is driven per access so that lane placement sees more than one word
  logic [31:0] reg_store_data = SD;
  logic [31:0] mem_read_data, mem_addr, mem_write_data, load_result;
  logic [3:0] mem_lane_mask;
  logic half_misaligned, bad_funct3;
  int n_mismatch = 0;
  int n_tests = 0;
  initial forever #5 clock = ~clock;
  load_store_lane_alignment #(.DATA_W(32), .LANES(4)) DUT (.clock(clock), .rst(rst),
    .alu_result(alu_result), .funct3(funct3), .reg_store_data(reg_store_data),
    .mem_read_data(mem_read_data), .mem_addr(mem_addr), .mem_lane_mask(mem_lane_mask),
    .mem_write_data(mem_write_data), .load_result(load_result),
    .half_misaligned(half_misaligned), .bad_funct3(bad_funct3));
  mem_word_model u_mem (.addr(alu_result), .rdata(mem_read_data));
  // ----
  // shared helpers
  // ----
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // drive at the falling edge, judge once the registered answer has landed
  task automatic access(input logic [31:0] a, input logic [2:0] f, input logic [3:0] m,
                        input logic [31:0] ld, input logic [31:0] wr, input logic [1:0] fl,
                        input logic [31:0] sd);
    @(negedge clock);
    alu_result = a;
    funct3 = f;
    reg_store_data = sd;
    @(posedge clock);
    #1;
    check("mem_addr", mem_addr, {a[31:2], 2'h0});
    check("mem_lane_mask", {28'h0, mem_lane_mask}, {28'h0, m});
    check("load_result", load_result, ld);
    check("mem_write_data", mem_write_data, wr);
    check("flags", {30'h0, half_misaligned, bad_funct3}, {30'h0, fl});
  endtask
  // ----
  // scenarios, issued back to back every cycle
  // ----
  task automatic t_bytes();
    logic [31:0] w;
    logic [31:0] s;
    logic [7:0] b;
    for (int k = 0; k < 16; k++) begin
      w = k[2] ? 32'hCAFEBABE : 32'h12345678;
      s = k[0] ? SD : ~SD;
      b = 8'(w >> (8 * k[1:0]));
      access(32'(k[2:0]), k[3] ? 3'h4 : 3'h0, 4'h1 << k[1:0],
        k[3] ? {24'h0, b} : {{24{b[7]}}, b},
        {24'h0, s[7:0]} << (8 * k[1:0]), 2'h0, s);
    end
    $display("test bytes done");
  endtask
  task automatic t_halves();
    logic [31:0] w;
    logic [31:0] s;
    logic [15:0] h;
    for (int k = 0; k < 16; k++) begin
      w = k[2] ? 32'hCAFEBABE : 32'h12345678;
      s = k[1] ? SD : ~SD;
      h = 16'(w >> (8 * k[1:0]));
      if (k[0]) begin
        access(32'(k[2:0]), k[3] ? 3'h5 : 3'h1, 4'h0, 32'h0, 32'h0, 2'h2, s);
      end else begin
        access(32'(k[2:0]), k[3] ? 3'h5 : 3'h1, k[1] ? 4'hC : 4'h3,
          k[3] ? {16'h0, h} : {{16{h[15]}}, h},
          {16'h0, s[15:0]} << (8 * k[1:0]), 2'h0, s);
      end
    end
    $display("test halves done");
  endtask
  task automatic t_word();
    logic [31:0] s;
    for (int k = 0; k < 8; k++) begin
      s = k[0] ? SD : ~SD;
      access(32'h80000000 | 32'(k), 3'h2, 4'hF,
        k[2] ? 32'hCAFEBABE : 32'h12345678, s, 2'h0, s);
    end
    $display("test word done");
  endtask
  // mid-run reset: every output must drop at once; address and mask must stay low while held
  task automatic t_reset();
    @(negedge clock);
    rst = 1'b1;
    #1;
    check("reset addr", mem_addr, 32'h0);
    check("reset mask", {28'h0, mem_lane_mask}, 32'h0);
    check("reset write", mem_write_data, 32'h0);
    check("reset load", load_result, 32'h0);
    check("reset flags", {30'h0, half_misaligned, bad_funct3}, 32'h0);
    @(posedge clock);
    #1;
    check("reset held addr", mem_addr, 32'h0);
    check("reset held mask", {28'h0, mem_lane_mask}, 32'h0);
    @(negedge clock);
    rst = 1'b0;
    $display("test reset done");
  endtask
  task automatic t_bad();
    access(32'h5, 3'h3, 4'h0, 32'h0, 32'h0, 2'h1, SD);
    access(32'h4, 3'h6, 4'h0, 32'h0, 32'h0, 2'h1, SD);
    access(32'h2, 3'h7, 4'h0, 32'h0, 32'h0, 2'h1, ~SD);
    $display("test bad codes done");
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clock);
    #1;
    check("reset mask", {28'h0, mem_lane_mask}, 32'h0);
    @(negedge clock);
    rst = 1'b0;
    t_bytes();
    t_halves();
    t_word();
    t_reset();
    t_bad();
    complete_run();
  end
endmodule

// ===== sim/mem_word_model.sv
// memory model answering the data port with fixed words
`timescale 1ns/1ps
module mem_word_model (
  input wire logic [31:0] addr,
  output logic [31:0] rdata
);
  // two words; bit 2 picks one, alignment bits ignored as memory does
  assign rdata = addr[2] ? 32'hCAFEBABE : 32'h12345678;
endmodule
